// >>> logic/clock_divider.sv
`timescale 1ns/100ps
module clock_divider #(
    parameter int CNT_W = 5
) (
    input  wire logic             i_clk,
    input  wire logic             i_rst_b,
    input  wire logic             i_tick,
    input  wire logic [CNT_W-1:0] i_half,
    output logic                  o_level
);
    logic [CNT_W-1:0] cnt_ff;
    logic             lvl_ff;
    wire              wrap = i_tick && ((cnt_ff + 1'b1) >= i_half);
    wire [CNT_W-1:0]  nxt_cnt = wrap ? '0 : (i_tick ? cnt_ff + 1'b1 : cnt_ff);

    // Level toggles once every i_half ticks of the PLL output
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            cnt_ff <= '0;
            lvl_ff <= 1'b0;
        end else begin
            cnt_ff <= nxt_cnt;
            lvl_ff <= wrap ? ~lvl_ff : lvl_ff;
        end
    end
    assign o_level = lvl_ff;
endmodule

// >>> logic/pll_clock_control.sv
// Summary of operation
// - Fraction mode bit, reset 1; zero ignores the fractional value.
// - Master select bit, reset 0: 0 pin input, 1 pin output.
// - Master clock source bit, reset 0: divided clock two or oscillator.
// - Rate select only applies to PLL source; oscillator passes unchanged.
// - Divided clock one factors from post divider and clock out codes.
// - Divided clock two factors from post divider and master divide.
// - Receive mode gives the fs multiples through the same dividers.
// - Master clock is reference for audio interface and transmitter.
// - Pin as input: transmitter reference follows the pin clock.
// - Predivide bit selects oscillator divided by one or two.
// - Ratio is integer plus 22-bit fraction; integer in low nibble.
// - Enabled receiver drives the post divider select itself.
`timescale 1ns/100ps
`include "pll_clock_map.svh"
module pll_clock_control #(
    parameter int ADDR_W = 8
) (
    input  wire logic                      I_SYS_CLK,
    input  wire logic                      I_RST_B,
    input  wire logic [ADDR_W-1:0]         I_AWADDR,
    input  wire logic                      I_AWVALID,
    output logic                           O_AWREADY,
    input  wire logic [31:0]               I_WDATA,
    input  wire logic [3:0]                I_WSTRB,
    input  wire logic                      I_WVALID,
    output logic                           O_WREADY,
    output logic [1:0]                     O_BRESP,
    output logic                           O_BVALID,
    input  wire logic                      I_BREADY,
    input  wire logic [ADDR_W-1:0]         I_ARADDR,
    input  wire logic                      I_ARVALID,
    output logic                           O_ARREADY,
    output logic [31:0]                    O_RDATA,
    output logic [1:0]                     O_RRESP,
    output logic                           O_RVALID,
    input  wire logic                      I_RREADY,
    input  wire logic                      I_F2_TICK,
    input  wire logic                      I_OSC_CLK,
    input  wire logic                      I_MCLK_I,
    input  wire logic                      I_RX_ENABLE,
    input  wire pll_clock_pkg::post_div_t  I_RX_POST_DIV,
    output logic                           O_MCLK_O,
    output logic                           O_MCLK_OE,
    output logic                           O_DIVIDED_CLOCK_ONE,
    output logic                           O_DIVIDED_CLOCK_TWO,
    output logic                           O_AIF_REF_CLK,
    output logic                           O_TX_REF_CLK,
    output logic [3:0]                     O_PLL_N,
    output logic [21:0]                    O_PLL_K,
    output logic                           O_PLL_PREDIV,
    output logic                           O_FRAC_EN,
    output pll_clock_pkg::post_div_t       O_POST_DIV
);
    import pll_clock_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Register storage
    logic [7:0]  k_lo_ff;
    logic [7:0]  k_mid_ff;
    logic [7:0]  k_hi_ff;
    logic [7:0]  int_ff;
    logic [7:0]  div_ctrl_ff;
    logic [7:0]  clk_sel_ff;
    logic [7:0]  aif_ff;
    pll_mode_t   mode_ff;

    ////////////////////////////////////////////////////////////////////////
    // Bus slave
    logic        awready_ff;
    logic        wready_ff;
    logic        bvalid_ff;
    logic [1:0]  bresp_ff;
    logic        arready_ff;
    logic        rvalid_ff;
    logic [1:0]  rresp_ff;
    logic [31:0] rdata_ff;

    wire       wr_take = I_AWVALID && I_WVALID && !awready_ff && !bvalid_ff;
    wire       wr_do   = awready_ff;
    wire [5:0] wr_idx  = I_AWADDR[7:2];
    wire       wr_lane = wr_do && I_WSTRB[0];
    wire       rd_take = I_ARVALID && !arready_ff && !rvalid_ff;
    wire [5:0] rd_idx  = I_ARADDR[7:2];

    wire wr_k_lo  = wr_lane && (wr_idx == `IDX_PLL_K_LO);
    wire wr_k_mid = wr_lane && (wr_idx == `IDX_PLL_K_MID);
    wire wr_k_hi  = wr_lane && (wr_idx == `IDX_PLL_K_HI);
    wire wr_int   = wr_lane && (wr_idx == `IDX_PLL_INT);
    wire wr_div   = wr_lane && (wr_idx == `IDX_DIV_CTRL);
    wire wr_sel   = wr_lane && (wr_idx == `IDX_CLK_SEL);
    wire wr_aif   = wr_lane && (wr_idx == `IDX_AIF_RX_CTRL);

    function automatic logic mapped(input logic [5:0] idx);
        mapped = (idx == `IDX_PLL_K_LO) || (idx == `IDX_PLL_K_MID) ||
                 (idx == `IDX_PLL_K_HI) || (idx == `IDX_PLL_INT) ||
                 (idx == `IDX_DIV_CTRL) || (idx == `IDX_CLK_SEL) ||
                 (idx == `IDX_AIF_RX_CTRL) || (idx == `IDX_CLK_STATUS);
    endfunction

    wire [7:0] status_w;
    wire [7:0] rd_byte =
        (rd_idx == `IDX_PLL_K_LO)    ? k_lo_ff     :
        (rd_idx == `IDX_PLL_K_MID)   ? k_mid_ff    :
        (rd_idx == `IDX_PLL_K_HI)    ? k_hi_ff     :
        (rd_idx == `IDX_PLL_INT)     ? int_ff      :
        (rd_idx == `IDX_DIV_CTRL)    ? div_ctrl_ff :
        (rd_idx == `IDX_CLK_SEL)     ? clk_sel_ff  :
        (rd_idx == `IDX_AIF_RX_CTRL) ? aif_ff      :
        (rd_idx == `IDX_CLK_STATUS)  ? status_w    : 8'h00;

    always_ff @(posedge I_SYS_CLK) begin
        if (!I_RST_B) begin
            awready_ff <= 1'b0;
            wready_ff  <= 1'b0;
            bvalid_ff  <= 1'b0;
            bresp_ff   <= `RESP_OKAY;
        end else begin
            awready_ff <= wr_take;
            wready_ff  <= wr_take;
            bvalid_ff  <= wr_do ? 1'b1 : (bvalid_ff && !I_BREADY);
            bresp_ff   <= wr_do ? (mapped(wr_idx) ? `RESP_OKAY : `RESP_SLVERR)
                                : bresp_ff;
        end
    end

    always_ff @(posedge I_SYS_CLK) begin
        if (!I_RST_B) begin
            arready_ff <= 1'b0;
            rvalid_ff  <= 1'b0;
            rresp_ff   <= `RESP_OKAY;
            rdata_ff   <= 32'h0000_0000;
        end else begin
            arready_ff <= rd_take;
            rvalid_ff  <= arready_ff ? 1'b1 : (rvalid_ff && !I_RREADY);
            rresp_ff   <= arready_ff ? (mapped(rd_idx) ? `RESP_OKAY : `RESP_SLVERR)
                                     : rresp_ff;
            rdata_ff   <= arready_ff ? {24'h00_0000, rd_byte} : rdata_ff;
        end
    end

    // Fraction high byte keeps all eight bits; only bits 5:0 enter the fraction
    always_ff @(posedge I_SYS_CLK) begin
        if (!I_RST_B) begin
            k_lo_ff     <= `RST_PLL_K_LO;
            k_mid_ff    <= `RST_PLL_K_MID;
            k_hi_ff     <= `RST_PLL_K_HI;
            int_ff      <= `RST_PLL_INT;
            div_ctrl_ff <= `RST_DIV_CTRL;
            clk_sel_ff  <= `RST_CLK_SEL;
            aif_ff      <= `RST_AIF_RX_CTRL;
        end else begin
            k_lo_ff     <= wr_k_lo  ? I_WDATA[7:0] : k_lo_ff;
            k_mid_ff    <= wr_k_mid ? I_WDATA[7:0] : k_mid_ff;
            k_hi_ff     <= wr_k_hi  ? I_WDATA[7:0] : k_hi_ff;
            int_ff      <= wr_int   ? I_WDATA[7:0] : int_ff;
            div_ctrl_ff <= wr_div   ? I_WDATA[7:0] : div_ctrl_ff;
            clk_sel_ff  <= wr_sel   ? I_WDATA[7:0] : clk_sel_ff;
            aif_ff      <= wr_aif   ? I_WDATA[7:0] : aif_ff;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Field decode
    wire        frac_en    = div_ctrl_ff[`POS_FRAC_MODE];
    wire        mclk_div   = div_ctrl_ff[`POS_MCLK_DIVIDE];
    wire [1:0]  clkout_div = div_ctrl_ff[`POS_CLKOUT_DIV+1:`POS_CLKOUT_DIV];
    wire        mclk_osc   = clk_sel_ff[`POS_MCLK_SOURCE];
    wire        if_master  = aif_ff[`POS_IF_MASTER];
    wire        predivide  = int_ff[`POS_PREDIVIDE];
    wire [3:0]  int_part   = int_ff[`POS_INT_PART_MSB:0];
    wire [21:0] frac_part  = {k_hi_ff[`POS_K_HI_MSB:0], k_mid_ff, k_lo_ff};
    wire [21:0] frac_eff   = frac_en ? frac_part : 22'h00_0000;
    wire [1:0]  user_pdiv  = div_ctrl_ff[`POS_POST_DIV_MSB:0];
    // Receiver owns the post divider while enabled
    wire [1:0]  post_div   = I_RX_ENABLE ? I_RX_POST_DIV : user_pdiv;

    assign status_w = {4'h0, if_master, mode_ff == MODE_RX, post_div};

    always_ff @(posedge I_SYS_CLK) begin
        if (!I_RST_B) begin
            mode_ff <= MODE_USER;
        end else begin
            case (mode_ff)
                MODE_USER: mode_ff <= I_RX_ENABLE ? MODE_RX : MODE_USER;
                MODE_RX:   mode_ff <= I_RX_ENABLE ? MODE_RX : MODE_USER;
                default:   mode_ff <= MODE_USER;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Post dividers: half periods in f2 ticks
    function automatic half_count_t divided_clock_one_half(input logic [1:0] fm,
                                              input logic [1:0] cod);
        case ({fm, cod})
            4'b0000: divided_clock_one_half = 5'h01;
            4'b0001: divided_clock_one_half = 5'h01;
            4'b0010: divided_clock_one_half = 5'h02;
            4'b0011: divided_clock_one_half = 5'h04;
            4'b0100: divided_clock_one_half = 5'h01;
            4'b0101: divided_clock_one_half = 5'h02;
            4'b0110: divided_clock_one_half = 5'h04;
            4'b0111: divided_clock_one_half = 5'h08;
            4'b1000: divided_clock_one_half = 5'h02;
            4'b1001: divided_clock_one_half = 5'h04;
            4'b1010: divided_clock_one_half = 5'h08;
            4'b1011: divided_clock_one_half = 5'h10;
            4'b1100: divided_clock_one_half = 5'h03;
            4'b1101: divided_clock_one_half = 5'h06;
            4'b1110: divided_clock_one_half = 5'h0c;
            default: divided_clock_one_half = 5'h18;
        endcase
    endfunction

    function automatic half_count_t divided_clock_two_half(input logic [1:0] fm,
                                              input logic       md);
        case ({fm, md})
            3'b000:  divided_clock_two_half = 5'h01;
            3'b001:  divided_clock_two_half = 5'h02;
            3'b010:  divided_clock_two_half = 5'h02;
            3'b011:  divided_clock_two_half = 5'h04;
            3'b100:  divided_clock_two_half = 5'h04;
            3'b101:  divided_clock_two_half = 5'h08;
            3'b110:  divided_clock_two_half = 5'h06;
            default: divided_clock_two_half = 5'h0c;
        endcase
    endfunction

    wire half_count_t half1 = divided_clock_one_half(post_div, clkout_div);
    wire half_count_t half2 = divided_clock_two_half(post_div, mclk_div);
    wire              divided_clock_one_lvl;
    wire              divided_clock_two_lvl;

    clock_divider #(.CNT_W(5)) u_div_one (
        .i_clk   (I_SYS_CLK),
        .i_rst_b (I_RST_B),
        .i_tick  (I_F2_TICK),
        .i_half  (half1),
        .o_level (divided_clock_one_lvl)
    );

    clock_divider #(.CNT_W(5)) u_div_two (
        .i_clk   (I_SYS_CLK),
        .i_rst_b (I_RST_B),
        .i_tick  (I_F2_TICK),
        .i_half  (half2),
        .o_level (divided_clock_two_lvl)
    );

    ////////////////////////////////////////////////////////////////////////
    // Master clock pin and references
    wire mclk_src = mclk_osc ? I_OSC_CLK : divided_clock_two_lvl;
    wire pin_lvl  = if_master ? mclk_src : I_MCLK_I;

    always_ff @(posedge I_SYS_CLK) begin
        if (!I_RST_B) begin
            O_MCLK_O      <= 1'b0;
            O_MCLK_OE     <= 1'b0;
            O_DIVIDED_CLOCK_ONE        <= 1'b0;
            O_DIVIDED_CLOCK_TWO        <= 1'b0;
            O_AIF_REF_CLK <= 1'b0;
            O_TX_REF_CLK  <= 1'b0;
        end else begin
            O_MCLK_O      <= if_master ? mclk_src : 1'b0;
            O_MCLK_OE     <= if_master;
            O_DIVIDED_CLOCK_ONE        <= divided_clock_one_lvl;
            O_DIVIDED_CLOCK_TWO        <= divided_clock_two_lvl;
            O_AIF_REF_CLK <= pin_lvl;
            O_TX_REF_CLK  <= pin_lvl;
        end
    end

    always_ff @(posedge I_SYS_CLK) begin
        if (!I_RST_B) begin
            O_PLL_N      <= 4'h0;
            O_PLL_K      <= 22'h00_0000;
            O_PLL_PREDIV <= 1'b0;
            O_FRAC_EN    <= 1'b0;
            O_POST_DIV   <= 2'h0;
        end else begin
            O_PLL_N      <= int_part;
            O_PLL_K      <= frac_eff;
            O_PLL_PREDIV <= predivide;
            O_FRAC_EN    <= frac_en;
            O_POST_DIV   <= post_div;
        end
    end

    assign O_AWREADY = awready_ff;
    assign O_WREADY  = wready_ff;
    assign O_BVALID  = bvalid_ff;
    assign O_BRESP   = bresp_ff;
    assign O_ARREADY = arready_ff;
    assign O_RVALID  = rvalid_ff;
    assign O_RRESP   = rresp_ff;
    assign O_RDATA   = rdata_ff;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge I_SYS_CLK); endclocking
    default disable iff (!I_RST_B);

    // Outputs leave reset on the same edge as the registers and follow them one edge later
    AST_INT_MODE_K: assert property (I_RST_B |=> O_PLL_K ==
        ($past(frac_en) ? $past(frac_part) : 22'h00_0000))
        else $error("fraction not gated by mode");
    AST_PIN_DIR: assert property (##1 O_MCLK_OE == $past(if_master))
        else $error("pin direction wrong");
    AST_OSC_SRC: assert property (if_master && mclk_osc |=>
        O_MCLK_O == $past(I_OSC_CLK))
        else $error("oscillator not on pin");
    AST_PLL_SRC: assert property (if_master && !mclk_osc |=>
        O_MCLK_O == O_DIVIDED_CLOCK_TWO)
        else $error("divided clock two not on pin");
    AST_SLAVE_REF: assert property (I_RST_B && !if_master |=>
        (!O_MCLK_OE && !O_MCLK_O && O_AIF_REF_CLK == $past(I_MCLK_I)))
        else $error("slave pin driven or wrong reference");
    AST_SHARED_REF: assert property (O_TX_REF_CLK == O_AIF_REF_CLK)
        else $error("references differ");
    AST_RX_OVERRIDE: assert property (I_RX_ENABLE |=>
        O_POST_DIV == $past(I_RX_POST_DIV))
        else $error("receiver not driving post divider");
    AST_PREDIV: assert property (##1 O_PLL_PREDIV == $past(predivide))
        else $error("predivide not passed");
    AST_INT_PART: assert property (I_RST_B |=> O_PLL_N == $past(int_part))
        else $error("integer part not passed");
    AST_DIVIDED_CLOCK_TWO_RATE: assert property (I_F2_TICK && post_div == 2'h0 &&
        !mclk_div && $stable(post_div) && $stable(mclk_div) |=>
        divided_clock_two_lvl != $past(divided_clock_two_lvl))
        else $error("divide by two not toggling each tick");
    AST_BHOLD: assert property (O_BVALID && !I_BREADY |=> O_BVALID)
        else $error("write answer dropped");
    AST_RHOLD: assert property (O_RVALID && !I_RREADY |=>
        O_RVALID && $stable(O_RDATA))
        else $error("read answer dropped");

    COV_RX_MODE: cover property (mode_ff == MODE_USER ##1 mode_ff == MODE_RX);
    COV_MASTER_OSC: cover property (O_MCLK_OE && mclk_osc);
    COV_WRITE: cover property (O_BVALID && I_BREADY && O_BRESP == `RESP_OKAY);
    COV_READ_ERR: cover property (O_RVALID && O_RRESP == `RESP_SLVERR);
endmodule

// >>> logic/pll_clock_map.svh
`ifndef PLL_CLOCK_MAP_SVH
`define PLL_CLOCK_MAP_SVH

// Register indexes; byte address is four times the index
`define IDX_PLL_K_LO      6'h03
`define IDX_PLL_K_MID     6'h04
`define IDX_PLL_K_HI      6'h05
`define IDX_PLL_INT       6'h06
`define IDX_DIV_CTRL      6'h07
`define IDX_CLK_SEL       6'h08
`define IDX_AIF_RX_CTRL   6'h1c
`define IDX_CLK_STATUS    6'h20

// Reset values
`define RST_PLL_K_LO      8'h21
`define RST_PLL_K_MID     8'hfd
`define RST_PLL_K_HI      8'h36
`define RST_PLL_INT       8'h07
`define RST_DIV_CTRL      8'h16
`define RST_CLK_SEL       8'h18
`define RST_AIF_RX_CTRL   8'h00

// Field positions
`define POS_INT_PART_MSB  3
`define POS_PREDIVIDE     4
`define POS_POST_DIV_MSB  1
`define POS_FRAC_MODE     2
`define POS_MCLK_DIVIDE   3
`define POS_CLKOUT_DIV    4
`define POS_MCLK_SOURCE   7
`define POS_IF_MASTER     6
`define POS_K_HI_MSB      5

// Bus answers
`define RESP_OKAY         2'h0
`define RESP_SLVERR       2'h2

`endif

// >>> logic/pll_clock_pkg.sv
package pll_clock_pkg;
    typedef enum logic [1:0] {
        MODE_USER = 2'b01,
        MODE_RX   = 2'b10
    } pll_mode_t;
    typedef logic [1:0] post_div_t;
    typedef logic [4:0] half_count_t;
endpackage

// >>> sim/ext_mclk_model.sv
`timescale 1ns/100ps
module ext_mclk_model #(
    parameter int HALF = 5
) (
    input  wire logic i_clk,
    input  wire logic i_oe,
    input  wire logic i_drv,
    output logic      o_pin
);
    logic [3:0] cnt_ff = 4'h0;
    logic       lvl_ff = 1'b0;

    ////////////////////////////////////////////////////////////////////////////
    // Free-running clock of the external audio master
    always_ff @(posedge i_clk) begin
        if (cnt_ff == 4'(HALF - 1)) begin
            cnt_ff <= 4'h0;
            lvl_ff <= ~lvl_ff;
        end else begin
            cnt_ff <= cnt_ff + 4'h1;
        end
    end

    // Pin level: block drives it in master mode, this device otherwise
    assign o_pin = i_oe ? i_drv : lvl_ff;
endmodule

// >>> sim/tb.sv
`timescale 1ns/100ps
module tb;
    import pll_clock_pkg::*;
    logic        clk = 1'b0, rst_b = 1'b0;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic        arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic [3:0]  wstrb = 4'h0, strb = 4'hf;
    logic        tick = 1'b0, osc = 1'b0, rx_en = 1'b0;
    logic [1:0]  oc = 2'h0;
    post_div_t   rx_pd = 2'h0, post_div;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [1:0]  bresp, rresp;
    logic [31:0] rdata, d;
    logic        mclk_o, mclk_oe, divided_clock_one, divided_clock_two, aif_ref, tx_ref, prediv, frac_en, pin;
    logic [3:0]  pll_n;
    logic [21:0] pll_k;
    logic [1:0]  r;
    logic [2:0]  msel = 3'h0;
    int          fails = 0, checks = 0, cyc = 0;
    int          c1f[16] = '{2, 2, 4, 8, 2, 4, 8, 16, 4, 8, 16, 32, 6, 12, 24, 48};
    int          c2f[8] = '{2, 4, 4, 8, 8, 16, 12, 24};
    logic [5:0]  ri[7] = '{6'h03, 6'h04, 6'h05, 6'h06, 6'h07, 6'h08, 6'h1c};
    logic [7:0]  rv[7] = '{8'h21, 8'hfd, 8'h36, 8'h07, 8'h16, 8'h18, 8'h00};
    wire  [4:0]  mv = {aif_ref, tx_ref, mclk_o, divided_clock_two, divided_clock_one};
    wire         mon = mv[msel];

    pll_clock_control #(.ADDR_W(8)) dut (
        .I_SYS_CLK(clk), .I_RST_B(rst_b), .I_AWADDR(awaddr), .I_AWVALID(awvalid),
        .O_AWREADY(awready), .I_WDATA(wdata), .I_WSTRB(wstrb), .I_WVALID(wvalid),
        .O_WREADY(wready), .O_BRESP(bresp), .O_BVALID(bvalid), .I_BREADY(bready),
        .I_ARADDR(araddr), .I_ARVALID(arvalid), .O_ARREADY(arready), .O_RDATA(rdata),
        .O_RRESP(rresp), .O_RVALID(rvalid), .I_RREADY(rready), .I_F2_TICK(tick),
        .I_OSC_CLK(osc), .I_MCLK_I(pin), .I_RX_ENABLE(rx_en), .I_RX_POST_DIV(rx_pd),
        .O_MCLK_O(mclk_o), .O_MCLK_OE(mclk_oe), .O_DIVIDED_CLOCK_ONE(divided_clock_one), .O_DIVIDED_CLOCK_TWO(divided_clock_two),
        .O_AIF_REF_CLK(aif_ref), .O_TX_REF_CLK(tx_ref), .O_PLL_N(pll_n), .O_PLL_K(pll_k),
        .O_PLL_PREDIV(prediv), .O_FRAC_EN(frac_en), .O_POST_DIV(post_div)
    );

    ext_mclk_model #(.HALF(5)) ext (.i_clk(clk), .i_oe(mclk_oe), .i_drv(mclk_o), .o_pin(pin));

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        forever #4 clk = ~clk;
    end

    // Oscillator with a half period of three cycles; timeout guard
    always @(posedge clk) begin
        oc <= oc + 2'h1;
        if (oc == 2'h2) begin
            oc <= 2'h0;
            osc <= ~osc;
        end
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            fails++;
            report_and_stop();
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic report_and_stop();
        if (fails == 0 && checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [5:0] idx, input logic [7:0] v, output logic [1:0] rs);
        @(posedge clk);
        awaddr <= {idx, 2'b00};
        wdata <= {24'h0, v};
        wstrb <= strb;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clk);
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        rs = bresp;
        bready <= 1'b0;
        repeat (3) @(posedge clk);
    endtask

    task automatic rd(input logic [5:0] idx, output logic [31:0] v, output logic [1:0] rs);
        @(posedge clk);
        araddr <= {idx, 2'b00};
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clk);
            if (arready === 1'b1) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        v = rdata;
        rs = rresp;
        rready <= 1'b0;
    endtask

    task automatic rchk(input logic [5:0] idx, input logic [7:0] exp);
        rd(idx, d, r);
        chk({r, d}, {2'h0, 24'h0, exp});
    endtask

    task automatic wchk(input logic [5:0] idx, input logic [7:0] v);
        wr(idx, v, r);
        chk(r, 2'h0);
    endtask

    // Half period of the selected clock output, in system cycles
    task automatic meas(input logic [2:0] s, input int exp);
        logic p;
        int   n;
        msel = s;
        repeat (100) @(posedge clk);
        #1;
        p = mon;
        n = 0;
        while (mon === p && n < 200) begin
            @(posedge clk);
            #1;
            n++;
        end
        p = mon;
        n = 0;
        while (mon === p && n < 200) begin
            @(posedge clk);
            #1;
            n++;
        end
        chk(n, exp);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (8) @(posedge clk);
        rst_b <= 1'b1;
        tick <= 1'b1;
        for (int i = 0; i < 7; i++) rchk(ri[i], rv[i]);
        chk({pll_n, pll_k, prediv, frac_en}, {4'h7, 22'h36fd21, 2'b01});
        chk({mclk_oe, mclk_o}, 2'b00);
        meas(3'h3, 5);
        meas(3'h4, 5);
        wchk(6'h03, 8'hba);
        wchk(6'h04, 8'h49);
        wchk(6'h05, 8'h0c);
        wchk(6'h06, 8'h08);
        chk({pll_n, pll_k, prediv}, {4'h8, 22'h0c49ba, 1'b0});
        wchk(6'h06, 8'h18);
        chk({pll_n, prediv}, {4'h8, 1'b1});
        strb = 4'h0;
        wchk(6'h03, 8'h55);
        strb = 4'hf;
        rchk(6'h03, 8'hba);
        wchk(6'h07, 8'h12);
        chk({frac_en, pll_k}, 23'h0);
        wchk(6'h07, 8'h16);
        chk({frac_en, pll_k}, {1'b1, 22'h0c49ba});
        rd(6'h10, d, r);
        chk({r, d}, {2'h2, 32'h0});
        wr(6'h11, 8'h5a, r);
        chk(r, 2'h2);
        wchk(6'h1c, 8'h40);
        chk(mclk_oe, 1'b1);
        for (int pd = 0; pd < 4; pd++) begin
            for (int md = 0; md < 2; md++) begin
                wchk(6'h07, {4'h1, md[0], 1'b1, pd[1:0]});
                meas(3'h1, c2f[pd * 2 + md] / 2);
                meas(3'h2, c2f[pd * 2 + md] / 2);
            end
        end
        meas(3'h4, c2f[7] / 2);
        for (int pd = 0; pd < 4; pd++) begin
            for (int co = 0; co < 4; co++) begin
                wchk(6'h07, {2'h0, co[1:0], 2'b01, pd[1:0]});
                meas(3'h0, c1f[pd * 4 + co] / 2);
            end
        end
        wchk(6'h08, 8'h98);
        meas(3'h2, 3);
        meas(3'h3, 3);
        wchk(6'h07, 8'h1e);
        meas(3'h2, 3);
        wchk(6'h08, 8'h18);
        @(posedge clk);
        rx_en <= 1'b1;
        rx_pd <= 2'h3;
        wchk(6'h07, 8'h1c);
        chk(post_div, 2'h3);
        meas(3'h1, 12);
        meas(3'h0, 6);
        rchk(6'h20, 8'h0f);
        wchk(6'h1c, 8'h00);
        chk({mclk_oe, mclk_o}, 2'b00);
        meas(3'h4, 5);
        report_and_stop();
    end
endmodule
